//--- shared/capture_compare_unit_pkg.sv
/*
  Shared constants for the dual capture/compare array: register offsets,
  field positions, reset values, channel function codes, timer sources.
  Assumes a 32-bit classic Wishbone bus with byte addresses.
*/
package capture_compare_unit_pkg;

  // ----------------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------------
  localparam int CH_PER_UNIT = 16;
  localparam int NUM_UNITS   = 2;
  localparam int NUM_CH      = CH_PER_UNIT * NUM_UNITS;
  localparam int NUM_TMR     = 2 * NUM_UNITS;
  localparam int TMR_W       = 16;
  localparam int SEL_W       = 3;
  localparam int NUM_SEL     = 8;
  localparam int ADR_W       = 12;

  // ----------------------------------------------------------------------
  // prescaler: finest step 200 ns at a 40 MHz cpu clock
  // ----------------------------------------------------------------------
  localparam int RES_NS       = 200;
  localparam int CPU_MHZ      = 40;
  localparam int BASE_DIV     = (RES_NS * CPU_MHZ) / 1000;
  localparam int BASE_DIV_LOG = $clog2(BASE_DIV);
  localparam int PRESC_W      = BASE_DIV_LOG + NUM_SEL - 1;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [ADR_W-1:0] ADR_VALUE  = 12'h000;
  localparam logic [ADR_W-1:0] ADR_CHCTL  = 12'h080;
  localparam logic [ADR_W-1:0] ADR_TCTL   = 12'h100;
  localparam logic [ADR_W-1:0] ADR_RELOAD = 12'h110;
  localparam logic [ADR_W-1:0] ADR_COUNT  = 12'h120;
  localparam logic [ADR_W-1:0] ADR_CHREQ  = 12'h130;
  localparam logic [ADR_W-1:0] ADR_TREQ   = 12'h134;
  localparam logic [ADR_W-1:0] ADR_PINS   = 12'h138;

  // ----------------------------------------------------------------------
  // channel control fields
  // ----------------------------------------------------------------------
  localparam int CTL_W      = 5;
  localparam int CTL_TSEL   = 0;
  localparam int CTL_FN_LSB = 1;
  localparam int CTL_DBL    = 4;
  localparam logic [CTL_W-1:0] CHCTL_RST = 5'h00;

  typedef enum logic [2:0] {
    FN_OFF      = 3'b000,
    FN_CAP_RISE = 3'b001,
    FN_CAP_FALL = 3'b010,
    FN_CAP_BOTH = 3'b011,
    FN_CMP0     = 3'b100,
    FN_CMP1     = 3'b101,
    FN_CMP2     = 3'b110,
    FN_CMP3     = 3'b111
  } ch_fn_t;

  // ----------------------------------------------------------------------
  // timer control fields
  // ----------------------------------------------------------------------
  localparam int TCTL_W       = 6;
  localparam int TCTL_SEL_LSB = 0;
  localparam int TCTL_SRC_LSB = 3;
  localparam int TCTL_RUN     = 5;
  localparam logic [TCTL_W-1:0] TCTL_RST   = 6'h00;
  localparam logic [TMR_W-1:0]  RELOAD_RST = 16'h0000;
  localparam logic [TMR_W-1:0]  COUNT_RST  = 16'h0000;

  typedef enum logic [1:0] {
    SRC_PRESC = 2'b00,
    SRC_AUX   = 2'b01,
    SRC_EXT   = 2'b10
  } tmr_src_t;

  // channels 24..27 have no compare output
  localparam logic [NUM_CH-1:0] PIN_OUT_MASK = 32'hf0ff_ffff;

endpackage

//--- rtl/base_timer.sv
/*
  One 16-bit reloadable time-base timer with selectable input clock.
  Assumes prescaler ticks, the aux overflow pulse and the external
  count edge are single-cycle enables on clk_i.
*/
`timescale 1ns/1ps
module base_timer
  import capture_compare_unit_pkg::*;
#(
  parameter int W       = TMR_W,
  parameter bit HAS_EXT = 1'b1
)
(
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // count sources
  input  wire logic [NUM_SEL-1:0] tick_i,
  input  wire logic               aux_i,
  input  wire logic               ext_i,
  // configuration
  input  wire logic [SEL_W-1:0]   sel_i,
  input  wire logic [1:0]         src_i,
  input  wire logic               run_i,
  input  wire logic [W-1:0]       reload_i,
  input  wire logic               load_i,
  input  wire logic [W-1:0]       load_val_i,
  // state
  output logic      [W-1:0]       cnt_o,
  output logic                    step_o,
  output logic                    ovf_o
);

  logic adv;
  logic wrap;

  always_comb
  begin
    unique case (tmr_src_t'(src_i))
      SRC_PRESC: adv = tick_i[sel_i];
      SRC_AUX:   adv = aux_i;
      SRC_EXT:   adv = HAS_EXT & ext_i;
      default:   adv = 1'b0;
    endcase
  end

  assign wrap = &cnt_o;

  // ----------------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt_o <= W'(COUNT_RST);
    else if (load_i)
      cnt_o <= load_val_i;
    else if (run_i && adv)
      cnt_o <= wrap ? reload_i : cnt_o + 1'b1;
  end

  // ----------------------------------------------------------------------
  // step and overflow pulses, aligned with the new count
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      step_o <= 1'b0;
      ovf_o  <= 1'b0;
    end
    else
    begin
      step_o <= run_i & adv & ~load_i;
      ovf_o  <= run_i & adv & ~load_i & wrap;
    end
  end

endmodule

//--- rtl/dual_capture_compare_array.sv
/*
  Two capture/compare units, sixteen channels and two time bases each,
  behind a 32-bit classic Wishbone slave.
  Assumes pins and external count inputs are asynchronous; the aux timer
  overflow pulse comes from logic on clk_i.
*/
`timescale 1ns/1ps
module dual_capture_compare_array
  import capture_compare_unit_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // channel pins
  input  wire logic [NUM_CH-1:0] cc_pin_i,
  output logic      [NUM_CH-1:0] cc_pin_o,
  output logic      [NUM_CH-1:0] cc_pin_oe_o,
  // count inputs
  input  wire logic [1:0]        ext_count_i,
  input  wire logic              aux_ovf_i,
  // request flags
  output logic      [NUM_CH-1:0] ch_req_o,
  output logic      [NUM_TMR-1:0] tmr_req_o
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        r[8*b +: 8] = new_v[8*b +: 8];
    return r;
  endfunction

  function automatic logic is_cmp(input logic [CTL_W-1:0] c);
    return c[CTL_FN_LSB + 2];
  endfunction

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  logic        wr;
  logic        wr_value;
  logic        wr_chctl;
  logic        wr_tctl;
  logic        wr_reload;
  logic        wr_count;
  logic        wr_chreq;
  logic        wr_treq;
  logic [4:0]  ch_idx;
  logic [1:0]  tm_idx;
  logic [31:0] rd_data;

  assign wr        = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign ch_idx    = wb_adr_i[6:2];
  assign tm_idx    = wb_adr_i[3:2];
  assign wr_value  = wr && wb_adr_i[11:7] == ADR_VALUE[11:7];
  assign wr_chctl  = wr && wb_adr_i[11:7] == ADR_CHCTL[11:7];
  assign wr_tctl   = wr && wb_adr_i[11:4] == ADR_TCTL[11:4];
  assign wr_reload = wr && wb_adr_i[11:4] == ADR_RELOAD[11:4];
  assign wr_count  = wr && wb_adr_i[11:4] == ADR_COUNT[11:4];
  assign wr_chreq  = wr && wb_adr_i[11:2] == ADR_CHREQ[11:2];
  assign wr_treq   = wr && wb_adr_i[11:2] == ADR_TREQ[11:2];

  // ----------------------------------------------------------------------
  // input synchronisers and edge detection
  // ----------------------------------------------------------------------
  logic [NUM_CH-1:0] pin_m;
  logic [NUM_CH-1:0] pin_s;
  logic [NUM_CH-1:0] pin_d;
  logic [1:0]        ext_m;
  logic [1:0]        ext_s;
  logic [1:0]        ext_d;
  logic [NUM_CH-1:0] rise;
  logic [NUM_CH-1:0] fall;
  logic [1:0]        ext_edge;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_m <= '0;
      pin_s <= '0;
      pin_d <= '0;
      ext_m <= '0;
      ext_s <= '0;
      ext_d <= '0;
    end
    else
    begin
      pin_m <= cc_pin_i;
      pin_s <= pin_m;
      pin_d <= pin_s;
      ext_m <= ext_count_i;
      ext_s <= ext_m;
      ext_d <= ext_s;
    end
  end

  assign rise     = pin_s & ~pin_d;
  assign fall     = ~pin_s & pin_d;
  assign ext_edge = ext_s & ~ext_d;

  // ----------------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------------
  logic [PRESC_W-1:0] presc;
  logic [NUM_SEL-1:0] tick;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      presc <= '0;
    else
      presc <= presc + 1'b1;
  end

  generate
    for (genvar k = 0; k < NUM_SEL; k++)
    begin : g_tick
      assign tick[k] = &presc[BASE_DIV_LOG + k - 1:0];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // time-base timers: 0,1 unit a; 2,3 unit b
  // ----------------------------------------------------------------------
  logic [TCTL_W-1:0] tctl   [NUM_TMR];
  logic [TMR_W-1:0]  reload [NUM_TMR];
  logic [TMR_W-1:0]  tcnt   [NUM_TMR];
  logic [NUM_TMR-1:0] tstep;
  logic [NUM_TMR-1:0] tovf;
  logic [NUM_TMR-1:0] treq;

  generate
    for (genvar t = 0; t < NUM_TMR; t++)
    begin : g_tmr
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          tctl[t]   <= TCTL_RST;
          reload[t] <= RELOAD_RST;
        end
        else
        begin
          if (wr_tctl && tm_idx == t)
            tctl[t] <= TCTL_W'(merge(32'(tctl[t]), wb_dat_i, wb_sel_i));
          if (wr_reload && tm_idx == t)
            reload[t] <= TMR_W'(merge(32'(reload[t]), wb_dat_i, wb_sel_i));
        end
      end

      base_timer #(
        .W       (TMR_W),
        .HAS_EXT (t % 2 == 0)
      ) u_tmr (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .tick_i     (tick),
        .aux_i      (aux_ovf_i),
        .ext_i      (ext_edge[t / 2]),
        .sel_i      (tctl[t][TCTL_SEL_LSB +: SEL_W]),
        .src_i      (tctl[t][TCTL_SRC_LSB +: 2]),
        .run_i      (tctl[t][TCTL_RUN]),
        .reload_i   (reload[t]),
        .load_i     (wr_count && tm_idx == t),
        .load_val_i (TMR_W'(merge(32'(tcnt[t]), wb_dat_i, wb_sel_i))),
        .cnt_o      (tcnt[t]),
        .step_o     (tstep[t]),
        .ovf_o      (tovf[t])
      );

      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          treq[t] <= 1'b0;
        else if (tovf[t])
          treq[t] <= 1'b1;
        else if (wr_treq && wb_sel_i[0] && wb_dat_i[t])
          treq[t] <= 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------------
  logic [TMR_W-1:0]  value [NUM_CH];
  logic [CTL_W-1:0]  chctl [NUM_CH];
  logic [NUM_CH-1:0] match;
  logic [NUM_CH-1:0] cap;
  logic [NUM_CH-1:0] once;
  logic [NUM_CH-1:0] chreq;

  generate
    for (genvar i = 0; i < NUM_CH; i++)
    begin : g_ch
      localparam int UNIT = i / CH_PER_UNIT;
      localparam int LOC  = i % CH_PER_UNIT;
      logic [1:0]   tsel;
      ch_fn_t       fn;
      logic         part_hit;

      assign tsel = 2'(2 * UNIT) + {1'b0, chctl[i][CTL_TSEL]};
      assign fn   = ch_fn_t'(chctl[i][CTL_FN_LSB +: 3]);

      always_comb
      begin
        unique case (fn)
          FN_CAP_RISE: cap[i] = rise[i];
          FN_CAP_FALL: cap[i] = fall[i];
          FN_CAP_BOTH: cap[i] = rise[i] | fall[i];
          default:     cap[i] = 1'b0;
        endcase
      end

      // overflow rearms the guard in the same step, so reload can match
      assign match[i] = is_cmp(chctl[i]) && tstep[tsel]
                        && tcnt[tsel] == value[i]
                        && !((fn == FN_CMP2 || fn == FN_CMP3)
                             && once[i] && !tovf[tsel]);

      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          chctl[i] <= CHCTL_RST;
          value[i] <= '0;
        end
        else
        begin
          if (wr_chctl && ch_idx == i)
            chctl[i] <= CTL_W'(merge(32'(chctl[i]), wb_dat_i, wb_sel_i));
          if (cap[i])
            value[i] <= tcnt[tsel];
          else if (wr_value && ch_idx == i)
            value[i] <= TMR_W'(merge(32'(value[i]), wb_dat_i, wb_sel_i));
        end
      end

      // one-shot guard for modes 2 and 3, rearmed on overflow
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          once[i] <= 1'b0;
        else if (match[i])
          once[i] <= 1'b1;
        else if (tovf[tsel])
          once[i] <= 1'b0;
      end

      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          chreq[i] <= 1'b0;
        else if (cap[i] || match[i])
          chreq[i] <= 1'b1;
        else if (wr_chreq && wb_sel_i[i / 8] && wb_dat_i[i])
          chreq[i] <= 1'b0;
      end

      // partner of a low-half channel in double register mode
      if (LOC < CH_PER_UNIT / 2)
      begin : g_dbl
        assign part_hit = chctl[i][CTL_DBL] && match[i + CH_PER_UNIT / 2];
      end
      else
      begin : g_nodbl
        assign part_hit = 1'b0;
      end

      // pin driver
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          cc_pin_o[i]    <= 1'b0;
          cc_pin_oe_o[i] <= 1'b0;
        end
        else
        begin
          cc_pin_oe_o[i] <= PIN_OUT_MASK[i] && (fn == FN_CMP1
                            || fn == FN_CMP3 || chctl[i][CTL_DBL]);
          if (!PIN_OUT_MASK[i])
            cc_pin_o[i] <= 1'b0;
          else if (fn == FN_CMP1 && match[i] && part_hit)
            cc_pin_o[i] <= cc_pin_o[i];
          else if ((fn == FN_CMP1 && match[i]) || part_hit)
            cc_pin_o[i] <= ~cc_pin_o[i];
          else if (fn == FN_CMP3 && match[i])
            cc_pin_o[i] <= 1'b1;
          else if (fn == FN_CMP3 && tovf[tsel])
            cc_pin_o[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // read mux and acknowledge
  // ----------------------------------------------------------------------
  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (wb_adr_i[11:7] == ADR_VALUE[11:7])
      rd_data = 32'(value[ch_idx]);
    else if (wb_adr_i[11:7] == ADR_CHCTL[11:7])
      rd_data = 32'(chctl[ch_idx]);
    else if (wb_adr_i[11:4] == ADR_TCTL[11:4])
      rd_data = 32'(tctl[tm_idx]);
    else if (wb_adr_i[11:4] == ADR_RELOAD[11:4])
      rd_data = 32'(reload[tm_idx]);
    else if (wb_adr_i[11:4] == ADR_COUNT[11:4])
      rd_data = 32'(tcnt[tm_idx]);
    else if (wb_adr_i[11:2] == ADR_CHREQ[11:2])
      rd_data = chreq;
    else if (wb_adr_i[11:2] == ADR_TREQ[11:2])
      rd_data = 32'(treq);
    else if (wb_adr_i[11:2] == ADR_PINS[11:2])
      rd_data = pin_s;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= rd_data;
    end
  end

  // ----------------------------------------------------------------------
  // request outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ch_req_o  <= '0;
      tmr_req_o <= '0;
    end
    else
    begin
      ch_req_o  <= chreq;
      tmr_req_o <= treq;
    end
  end

endmodule

//--- bench/capture_compare_unit_pins_model.sv
/*
  Pin-side partner: channel pin levels, the two external count inputs
  and the aux timer overflow pulse.
  Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/1ps
module capture_compare_unit_pins_model
(
  // clock
  input  wire logic        clk_i,
  // driven lines
  output logic      [31:0] pin_o,
  output logic      [1:0]  ext_o,
  output logic             aux_o
);
  initial
  begin
    pin_o = 32'h0;
    ext_o = 2'h0;
    aux_o = 1'b0;
  end

  // ------
  // stimulus
  // ------
  task set_pin(input int ch, input logic v);
    @(posedge clk_i);
    pin_o[ch] <= v;
  endtask

  // one-cycle pulse per event
  task aux(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      aux_o <= 1'b1;
      @(posedge clk_i);
      aux_o <= 1'b0;
    end
  endtask

  // same wave on both inputs when m is 2'b11
  task ext(input logic [1:0] m, input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      ext_o <= m;
      repeat (4) @(posedge clk_i);
      ext_o <= 2'h0;
      repeat (4) @(posedge clk_i);
    end
  endtask
endmodule

//--- bench/dual_capture_compare_array_monitor.sv
/*
  Port checker for the capture/compare array.
  Assumes one clock and the synchronous active-high reset.
*/
`timescale 1ns/1ps
module dual_capture_compare_array_monitor
  import capture_compare_unit_pkg::*;
(
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // bus handshake
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_ack_o,
  // pins and flags
  input  wire logic [NUM_CH-1:0]  cc_pin_o,
  input  wire logic [NUM_CH-1:0]  cc_pin_oe_o,
  input  wire logic [NUM_CH-1:0]  ch_req_o,
  input  wire logic [NUM_TMR-1:0] tmr_req_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence s_pin_move;
    |((cc_pin_o ^ $past(cc_pin_o)) & cc_pin_oe_o & $past(cc_pin_oe_o));
  endsequence

  AST_ACK_ANSWER: assert property (s_take |=> s_answer)
    else $error("bus request not answered in one cycle");
  AST_ACK_CAUSE: assert property
    ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without a request");
  AST_CLEAN_RESET: assert property ($fell(rst_i) |->
    ch_req_o == '0 && tmr_req_o == '0 && cc_pin_oe_o == '0)
    else $error("outputs not cleared by reset");
  AST_NO_OUT_B: assert property (cc_pin_oe_o[27:24] == 4'h0)
    else $error("capture-only pin driven");
  AST_TREQ_CLEAR: assert property (|($past(tmr_req_o) & ~tmr_req_o)
    |-> $past(wb_ack_o) || $past(wb_ack_o, 2))
    else $error("timer flag dropped without a write");
  AST_CHREQ_CLEAR: assert property (|($past(ch_req_o) & ~ch_req_o)
    |-> $past(wb_ack_o) || $past(wb_ack_o, 2))
    else $error("channel flag dropped without a write");
  AST_OE_CFG: assert property ($changed(cc_pin_oe_o) |->
    $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3))
    else $error("pin direction moved without a write");
  AST_PIN_FLAG: assert property (s_pin_move |->
    ##[0:2] (|ch_req_o || |tmr_req_o))
    else $error("driven pin moved without a match flag");
endmodule

bind dual_capture_compare_array dual_capture_compare_array_monitor mon (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cc_pin_o(cc_pin_o),
  .cc_pin_oe_o(cc_pin_oe_o), .ch_req_o(ch_req_o),
  .tmr_req_o(tmr_req_o));

//--- bench/dual_capture_compare_array_bench.sv
/*
  Self-checking bench: bus tasks, one task per scenario, watchdog.
  Assumes the pin model and the bound port checker.
*/
`timescale 1ns/1ps
module dual_capture_compare_array_bench
  import capture_compare_unit_pkg::*;
;
  localparam logic [3:0] OE_E = 4'b1010;
  localparam logic [3:0] F2_E = 4'b0011;
  localparam logic [3:0] P2_E = 4'b1000;

  logic        clk_i = 1'b0;
  logic        rst_i, wb_cyc, wb_stb, wb_we, wb_ack_o, aux;
  logic [11:0] wb_adr;
  logic [3:0]  wb_sel, tmr_req;
  logic [31:0] wb_dat, wb_dat_o, pin_in, pin_o, pin_oe, ch_req;
  logic [1:0]  ext;
  int          miscompares = 0;
  int          tests_run = 0;

  always #10 clk_i = ~clk_i;

  dual_capture_compare_array uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cc_pin_i(pin_in), .cc_pin_o(pin_o), .cc_pin_oe_o(pin_oe),
    .ext_count_i(ext), .aux_ovf_i(aux), .ch_req_o(ch_req),
    .tmr_req_o(tmr_req));
  capture_compare_unit_pins_model pins (
    .clk_i(clk_i), .pin_o(pin_in), .ext_o(ext), .aux_o(aux));

  // ------
  // helpers
  // ------
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wb(input logic we, input logic [11:0] a,
                    input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= s;
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, 4'hf, q);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'hf, q);
    chk(q, e);
  endtask

  function automatic logic [31:0] tc(logic [1:0] s, logic [2:0] k);
    return (32'h1 << TCTL_RUN) | (32'(s) << TCTL_SRC_LSB) | 32'(k);
  endfunction

  function automatic logic [31:0] cc(logic [2:0] f, logic t, logic d);
    return (32'(d) << CTL_DBL) | (32'(f) << CTL_FN_LSB) | 32'(t);
  endfunction

  // ------
  // scenarios
  // ------
  task automatic t_regs;
    logic [31:0] q;
    rdchk(ADR_TCTL + 12'h00c, 32'h0);
    wr(ADR_RELOAD, 32'hffff_1234);
    rdchk(ADR_RELOAD, 32'h1234);
    wb(1'b1, ADR_RELOAD, 32'h0000_5600, 4'h2, q);
    rdchk(ADR_RELOAD, 32'h5634);
    wr(12'hffc, 32'hffff_ffff);
    rdchk(12'hffc, 32'h0);
    wr(ADR_CHCTL + 12'h040, 32'hffff_ffff);
    rdchk(ADR_CHCTL + 12'h040, 32'h1f);
    wr(ADR_CHCTL + 12'h040, 32'h0);
    wr(ADR_CHREQ, 32'hffff_ffff);
  endtask

  task automatic t_presc;
    logic [31:0] q;
    for (int k = 0; k < 8; k++)
    begin
      wr(ADR_TCTL + 12'h004, tc(SRC_PRESC, 3'(k)));
      wr(ADR_COUNT + 12'h004, 32'h0);
      tk((8 << k) * 4);
      wb(1'b0, ADR_COUNT + 12'h004, 32'h0, 4'hf, q);
      chk(32'(q inside {[4:5]}), 32'h1);
    end
  endtask

  task automatic t_ovf;
    wr(ADR_TCTL + 12'h004, tc(SRC_AUX, 3'h0));
    wr(ADR_RELOAD + 12'h004, 32'h0);
    wr(ADR_COUNT + 12'h004, 32'hfffe);
    wr(ADR_TREQ, 32'hf);
    pins.aux(2);
    tk(3);
    chk(tmr_req, 4'h2);
    rdchk(ADR_COUNT + 12'h004, 32'h0);
    wr(ADR_RELOAD + 12'h004, 32'h1230);
    wr(ADR_COUNT + 12'h004, 32'hffff);
    pins.aux(1);
    rdchk(ADR_COUNT + 12'h004, 32'h1230);
    wr(ADR_TREQ, 32'hf);
    tk(3);
    chk(tmr_req, 4'h0);
  endtask

  task automatic t_ext;
    wr(ADR_TCTL, tc(SRC_EXT, 3'h0));
    wr(ADR_TCTL + 12'h008, tc(SRC_EXT, 3'h0));
    wr(ADR_COUNT, 32'h0);
    wr(ADR_COUNT + 12'h008, 32'h0);
    pins.ext(2'b11, 3);
    rdchk(ADR_COUNT, 32'h3);
    rdchk(ADR_COUNT + 12'h008, 32'h3);
    pins.ext(2'b01, 1);
    rdchk(ADR_COUNT, 32'h4);
    rdchk(ADR_COUNT + 12'h008, 32'h3);
  endtask

  task automatic t_cap;
    logic [31:0] hit;
    wr(ADR_COUNT + 12'h008, 32'h0abc);
    for (int f = 1; f < 4; f++)
    begin
      hit = (f != 2) ? 32'h0100_0000 : 32'h0;
      wr(ADR_CHCTL + 12'h060, cc(3'(f), 1'b0, 1'b0));
      wr(ADR_VALUE + 12'h060, 32'h0);
      wr(ADR_CHREQ, 32'hffff_ffff);
      pins.set_pin(24, 1'b1);
      tk(8);
      chk(ch_req, hit);
      rdchk(ADR_PINS, 32'h0100_0000);
      rdchk(ADR_VALUE + 12'h060, (f != 2) ? 32'h0abc : 32'h0);
      wr(ADR_CHREQ, 32'hffff_ffff);
      pins.set_pin(24, 1'b0);
      tk(8);
      chk(ch_req[24], f != 1);
    end
  endtask

  task automatic t_cmp;
    logic oe;
    wr(ADR_RELOAD + 12'h004, 32'h0);
    for (int m = 0; m < 4; m++)
    begin
      oe = OE_E[m];
      wr(ADR_CHCTL + 12'h004, cc(3'(FN_CMP0 + m), 1'b1, 1'b0));
      wr(ADR_VALUE + 12'h004, 32'h5);
      wr(ADR_COUNT + 12'h004, 32'h0);
      wr(ADR_CHREQ, 32'hffff_ffff);
      pins.aux(5);
      tk(4);
      chk(ch_req, 32'h2);
      chk(pin_oe[1], oe);
      if (oe) chk(pin_o[1], 1'b1);
      wr(ADR_CHREQ, 32'hffff_ffff);
      wr(ADR_COUNT + 12'h004, 32'h4);
      pins.aux(1);
      tk(4);
      chk(ch_req[1], F2_E[m]);
      if (oe) chk(pin_o[1], P2_E[m]);
      wr(ADR_TREQ, 32'hf);
      wr(ADR_COUNT + 12'h004, 32'hffff);
      pins.aux(1);
      tk(4);
      chk(tmr_req, 4'h2);
      if (oe) chk(pin_o[1], 1'b0);
    end
  endtask

  task automatic t_dbl;
    wr(ADR_CHCTL + 12'h008, cc(FN_CMP1, 1'b1, 1'b1));
    wr(ADR_CHCTL + 12'h028, cc(FN_CMP0, 1'b1, 1'b0));
    wr(ADR_CHCTL + 12'h064, cc(FN_CMP1, 1'b0, 1'b0));
    wr(ADR_VALUE + 12'h008, 32'h3);
    wr(ADR_VALUE + 12'h028, 32'h6);
    wr(ADR_COUNT + 12'h004, 32'h0);
    pins.aux(3);
    tk(4);
    chk(pin_o[2] & pin_oe[2], 1'b1);
    pins.aux(3);
    tk(4);
    chk(pin_o[2], 1'b0);
    chk(pin_oe[25], 1'b0);
  endtask

  // reset in mid-run clears flags, directions and channel setup
  task automatic t_rst;
    tk(1);
    rst_i <= 1'b1;
    tk(3);
    rst_i <= 1'b0;
    chk(pin_oe, 32'h0);
    chk(ch_req, 32'h0);
    chk(tmr_req, 4'h0);
    rdchk(ADR_CHCTL + 12'h008, 32'h0);
  endtask

  // ------
  // run control
  // ------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    rst_i  = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we  = 1'b0;
    wb_adr = 12'h000;
    wb_sel = 4'h0;
    wb_dat = 32'h0;
    tk(3);
    rst_i <= 1'b0;
    t_regs;
    t_presc;
    t_ovf;
    t_ext;
    t_cap;
    t_cmp;
    t_dbl;
    t_rst;
    tally_and_finish;
  end

  // run is about 9k cycles
  initial
  begin
    #1_000_000;
    miscompares++;
    tally_and_finish;
  end
endmodule
